// [shared/spi_pkg.sv]
// Purpose: shared constants and helpers for the serial port block
// Assumes: 8-bit bytes, 20 MHz bus clock
// Notes: pin index constants order the pinOwned vector
package spi_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int PRE_W = 3;
  localparam int RATE_W = 4;
  localparam int HALF_W = 9;
  localparam int GAP_W = 12;
  localparam logic [RATE_W-1:0] RATE_MAX = 4'h8;
  localparam logic [3:0] EDGE_LAST = 4'hf;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SEL = 3;
  localparam int PIN_N = 4;

  typedef enum logic {XFER_IDLE, XFER_SHIFT} xfer_state_t;

  // bit presented on the data line next
  function automatic logic msbOf(input logic [DATA_W-1:0] b,
                                 input logic lsbf);
    return lsbf ? b[0] : b[DATA_W-1];
  endfunction : msbOf

  function automatic logic [DATA_W-1:0] shiftIn(
      input logic [DATA_W-1:0] b, input logic bitIn, input logic lsbf);
    return lsbf ? {bitIn, b[DATA_W-1:1]} : {b[DATA_W-2:0], bitIn};
  endfunction : shiftIn
endpackage : spi_pkg

// [shared/stream_if.sv]
// Purpose: valid/ready byte stream between internal modules
// Assumes: single clock domain
// Notes: src drives data, snk drives ready
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : stream_if

// [hw/byte_fifo.sv]
// Purpose: transmit byte queue ahead of the shifter
// Assumes: ce freezes all state; flush empties in one cycle
// Notes: ready already folds in ce so no push is lost while frozen
`timescale 1ns/1ps
module byte_fifo import spi_pkg::*; #(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk, // bus clock
  input wire logic rstn, // sync reset, low
  input wire logic ce, // clock enable
  input wire logic flush, // drop all words
  stream_if.snk wr, // filling side
  stream_if.src rd // draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;

  assign wr.ready = ce && !flush && (cnt_r != (AW+1)'(DEPTH));
  assign rd.valid = !flush && (cnt_r != '0);
  assign rd.data = mem[rp_r];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready && ce;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_r <= '0;
        rp_r <= '0;
        cnt_r <= '0;
      end else begin
        if (push) wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
        if (pop) rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
        cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= wr.data;
  end

  a_fifo_bounds: assert property (@(posedge clk) disable iff (!rstn)
    cnt_r <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule : byte_fifo

// [hw/rate_gen.sv]
// Purpose: master bit clock, prescaler then power-of-two divider
// Assumes: tick marks each serial clock half period
// Notes: rate codes above the top divisor clamp to it
`timescale 1ns/1ps
module rate_gen import spi_pkg::*; (
  input wire logic clk, // bus clock
  input wire logic rstn, // sync reset, low
  input wire logic ce, // clock enable
  input wire logic run, // counters cleared while low
  input wire logic [PRE_W-1:0] prescaleSelect, // divisor minus one
  input wire logic [RATE_W-1:0] rateSelect, // divide by 1 shl code
  output logic tick // one-cycle half-period pulse
);
  logic [PRE_W-1:0] preCnt_r;
  logic [HALF_W-1:0] rateCnt_r, rateLast;
  logic [RATE_W-1:0] rateEff;
  logic preTick;

  // half period is (pre+1) * 2^rate, so a full bit is (pre+1) * 2^(rate+1)
  assign rateEff = (rateSelect > RATE_MAX) ? RATE_MAX : rateSelect;
  assign rateLast = (HALF_W'(1) << rateEff) - HALF_W'(1);
  assign preTick = (preCnt_r == prescaleSelect);
  assign tick = run && ce && preTick && (rateCnt_r == rateLast);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      preCnt_r <= '0;
      rateCnt_r <= '0;
    end else if (ce) begin
      if (!run) begin
        preCnt_r <= '0;
        rateCnt_r <= '0;
      end else begin
        preCnt_r <= preTick ? '0 : preCnt_r + 1'b1;
        if (preTick) begin
          rateCnt_r <= (rateCnt_r == rateLast) ? '0 : rateCnt_r + 1'b1;
        end
      end
    end
  end

  logic [GAP_W-1:0] gap_r, gapWant;
  logic seen_r;
  assign gapWant = ({(GAP_W-PRE_W)'(0), prescaleSelect} + GAP_W'(1))
                   << rateEff;
  always_ff @(posedge clk) begin
    if (!rstn || !run || !$stable(prescaleSelect) || !$stable(rateSelect))
    begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (ce) begin
      gap_r <= tick ? '0 : gap_r + 1'b1;
      if (tick) seen_r <= 1'b1;
    end
  end

  a_rate_period: assert property (@(posedge clk) disable iff (!rstn)
    tick && seen_r && $stable(prescaleSelect) && $stable(rateSelect)
    |-> gap_r + GAP_W'(1) == gapWant)
    else $error("half period differs from prescale times rate");
endmodule : rate_gen

// [hw/spi_port.sv]
// Purpose: byte serial port, master or slave, full duplex or one wire
// Assumes: pin senses synchronous to clk; slave clock well below clk/2
// Notes: pins use sense/drive/driveEn triples; released pins drive 0
`timescale 1ns/1ps
module spi_port import spi_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk, // bus clock
  input wire logic rstn, // sync reset, low
  input wire logic clkEn, // freezes all state when low
  input wire logic stopShallow, // shallow stop: clocks halted
  input wire logic stopDeep, // deep stop: powered down
  input wire logic gateWrite, // load clock gate bit
  input wire logic gateValue, // new clock gate bit
  output logic gateEnable, // clock gate bit
  input wire logic systemEnableBit, // port enable
  input wire logic masterSelectBit, // 1 master, 0 slave
  input wire logic clockPolarityBit, // 1 clock idles high
  input wire logic clockPhaseBit, // 1 first edge at bit start
  input wire logic shiftDirectionBit, // 1 LSB first
  input wire logic bidirPinControl, // single-wire data
  input wire logic bidirOutputEnable, // single wire drives
  input wire logic modeFaultEnable, // master select pin in use
  input wire logic selectOutputEnable, // automatic select output
  input wire logic [PRE_W-1:0] prescaleSelect, // prescale code
  input wire logic [RATE_W-1:0] rateSelect, // rate code
  input wire logic [DATA_W-1:0] txData, // byte to send
  input wire logic txValid, // txData offered
  output logic txReady, // queue takes txData
  output logic transmitEmptyFlag, // nothing queued
  input wire logic rxRead, // software took rxData
  output logic [DATA_W-1:0] rxData, // received byte
  output logic receiveFullFlag, // rxData unread
  output logic busy, // byte in flight
  input wire logic serialClockSense, // clock pin level
  output logic serialClockDrive, // clock pin out
  output logic serialClockDriveEn, // clock pin driven
  input wire logic mosiSense, // MOSI pin level
  output logic mosiDrive, // MOSI out
  output logic mosiDriveEn, // MOSI driven
  input wire logic misoSense, // MISO pin level
  output logic misoDrive, // MISO out
  output logic misoDriveEn, // MISO driven
  input wire logic selectSense, // select pin level
  output logic selectDrive, // select out
  output logic selectDriveEn, // select driven
  output logic [PIN_N-1:0] pinOwned // pins under port control
);
  logic rstAll, ceAct, en, master, bidir, clock_polarity_bit, clock_phase_bit, lsbf, selected;
  logic gateEn_r;
  xfer_state_t state_r;
  logic [DATA_W-1:0] sh_r, shNext, rxBuf_r, rxByte;
  logic [3:0] edgeCnt_r;
  logic outBit_r, sckAct_r, sckPrev_r, rxFull_r;
  logic tick, mEdge, sEdge, edgeEv, leading, sampleEv, driveEv;
  logic lastEdge, inBit, start, done, abort;

  stream_if #(.W(DATA_W)) txIn();
  stream_if #(.W(DATA_W)) txOut();

  // deep stop loses everything; shallow stop only halts clocks
  assign rstAll = !rstn || stopDeep;
  assign ceAct = clkEn && gateEn_r && !stopShallow && !stopDeep;
  assign en = systemEnableBit;
  assign master = masterSelectBit;
  assign bidir = bidirPinControl;
  assign clock_polarity_bit = clockPolarityBit;
  assign clock_phase_bit = clockPhaseBit;
  assign lsbf = shiftDirectionBit;
  assign selected = !master && !selectSense;
  assign busy = (state_r == XFER_SHIFT);
  assign gateEnable = gateEn_r;

  always_ff @(posedge clk) begin
    if (rstAll) gateEn_r <= 1'b1;
    else if (clkEn && gateWrite) gateEn_r <= gateValue;
  end

  assign txIn.valid = txValid;
  assign txIn.data = txData;
  assign txReady = txIn.ready;
  assign txOut.ready = start && master || start && txOut.valid;
  assign transmitEmptyFlag = !txOut.valid;

  byte_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) txQueue (
    .clk(clk),
    .rstn(!rstAll),
    .ce(ceAct),
    .flush(!en),
    .wr(txIn),
    .rd(txOut)
  );

  rate_gen baud (
    .clk(clk),
    .rstn(!rstAll),
    .ce(ceAct),
    .run(en && master && busy),
    .prescaleSelect(prescaleSelect),
    .rateSelect(rateSelect),
    .tick(tick)
  );

  // slave edges come from the pin, compared against the previous sample
  assign mEdge = master && busy && tick;
  assign sEdge = !master && busy && selected &&
                 ((serialClockSense ^ clock_polarity_bit) != (sckPrev_r ^ clock_polarity_bit));
  assign edgeEv = ceAct && (mEdge || sEdge);
  assign leading = !edgeCnt_r[0];
  assign sampleEv = edgeEv && (leading ^ clock_phase_bit);
  assign driveEv = edgeEv && !(leading ^ clock_phase_bit);
  assign lastEdge = edgeEv && (edgeCnt_r == EDGE_LAST);
  assign inBit = master ? (bidir ? mosiSense : misoSense)
                        : (bidir ? misoSense : mosiSense);
  assign shNext = shiftIn(sh_r, inBit, lsbf);
  // master waits for a queued byte; slave arms as soon as selected
  assign start = ceAct && en && !busy &&
                 (master ? txOut.valid : selected);
  assign abort = !en || (!master && !selected);
  assign done = busy && lastEdge && !abort;
  assign rxByte = sampleEv ? shNext : sh_r;

  always_ff @(posedge clk) begin
    if (rstAll) sckPrev_r <= 1'b0;
    else if (ceAct) sckPrev_r <= serialClockSense;
  end

  always_ff @(posedge clk) begin
    if (rstAll) begin
      state_r <= XFER_IDLE;
      edgeCnt_r <= '0;
      sh_r <= RESET_BYTE;
      outBit_r <= 1'b0;
      sckAct_r <= 1'b0;
    end else if (ceAct) begin
      if (abort) begin
        state_r <= XFER_IDLE;
        edgeCnt_r <= '0;
        sckAct_r <= 1'b0;
        if (!en) sh_r <= RESET_BYTE;
      end else begin
        unique case (state_r)
          XFER_IDLE: begin
            if (start) begin
              state_r <= XFER_SHIFT;
              edgeCnt_r <= '0;
              sckAct_r <= 1'b0;
              // an empty queue in slave mode resends the last shift contents
              if (txOut.valid) sh_r <= txOut.data;
              outBit_r <= msbOf(txOut.valid ? txOut.data : sh_r, lsbf);
            end
          end
          XFER_SHIFT: begin
            if (edgeEv) begin
              edgeCnt_r <= edgeCnt_r + 1'b1;
              if (master) sckAct_r <= !sckAct_r;
            end
            if (sampleEv) sh_r <= shNext;
            if (driveEv) outBit_r <= msbOf(sh_r, lsbf);
            if (lastEdge) begin
              state_r <= XFER_IDLE;
              sckAct_r <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rstAll) begin
      rxBuf_r <= RESET_BYTE;
      rxFull_r <= 1'b0;
    end else if (ceAct) begin
      if (!en) begin
        rxBuf_r <= RESET_BYTE;
        rxFull_r <= 1'b0;
      end else if (done) begin
        rxBuf_r <= rxByte;
        rxFull_r <= 1'b1;
      end else if (rxRead) begin
        rxFull_r <= 1'b0;
      end
    end
  end

  assign rxData = rxBuf_r;
  assign receiveFullFlag = rxFull_r;

  // pin multiplexing; a pin not owned is left to the general port logic
  assign serialClockDriveEn = en && master;
  assign serialClockDrive = serialClockDriveEn && (clock_polarity_bit ^ sckAct_r);
  assign mosiDriveEn = en && master &&
                       (!bidir || bidirOutputEnable);
  assign mosiDrive = mosiDriveEn && outBit_r;
  assign misoDriveEn = en && !master &&
                       (bidir ? bidirOutputEnable : selected);
  assign misoDrive = misoDriveEn && outBit_r;
  assign selectDriveEn = en && master && modeFaultEnable &&
                         selectOutputEnable;
  assign selectDrive = selectDriveEn && !busy;
  assign pinOwned[PIN_SCK] = en;
  assign pinOwned[PIN_MOSI] = en && !(bidir && !master);
  assign pinOwned[PIN_MISO] = en && !(bidir && master);
  assign pinOwned[PIN_SEL] = en && (!master ||
                                    modeFaultEnable);

  logic [3:0] samples_r;
  always_ff @(posedge clk) begin
    if (rstAll || start) samples_r <= '0;
    else if (sampleEv) samples_r <= samples_r + 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rstAll);

  sequence masterStart;
    start && master;
  endsequence
  sequence byteEnd;
    done;
  endsequence

  a_tx_load: assert property (masterStart |=> busy &&
    sh_r == $past(txOut.data))
    else $error("queued byte not loaded at transfer start");
  a_rx_capture: assert property (byteEnd |=> receiveFullFlag &&
    rxData == $past(rxByte))
    else $error("received byte not moved to buffer");
  a_eight_bits: assert property (byteEnd |->
    samples_r + 4'(sampleEv) == BIT_COUNT)
    else $error("transfer did not carry eight bits");
  a_disable_clear: assert property (ceAct && !en |=> !receiveFullFlag &&
    transmitEmptyFlag && !busy)
    else $error("disable left buffers or state");
  a_pins_released: assert property (!en |-> pinOwned == '0 &&
    !serialClockDriveEn && !mosiDriveEn && !misoDriveEn &&
    !selectDriveEn)
    else $error("pin driven while disabled");
  a_clock_idle: assert property (en && master && !busy |->
    serialClockDrive == clock_polarity_bit)
    else $error("master clock not at idle level");
  a_bidir_pins: assert property (en && bidir |-> (master ?
    (!misoDriveEn && mosiDriveEn == bidirOutputEnable) :
    (!mosiDriveEn && misoDriveEn == bidirOutputEnable)))
    else $error("bidirectional pin routing wrong");
  a_select_auto: assert property (en && master && modeFaultEnable &&
    selectOutputEnable |-> selectDriveEn && selectDrive == !busy)
    else $error("automatic select output wrong");
  a_select_unused: assert property (en && master && !modeFaultEnable |->
    !selectDriveEn && !pinOwned[PIN_SEL])
    else $error("select pin used without mode fault");
  a_slave_deselect: assert property (ceAct && en && !master &&
    selectSense |=> !busy)
    else $error("slave shifting while not selected");
  a_stop_freeze: assert property (!ceAct ##1 !rstAll |->
    $stable(sh_r) && $stable(state_r) && $stable(rxBuf_r))
    else $error("state changed while clocks halted");
  a_gate_reset: assert property (@(posedge clk)
    $past(rstAll) |-> gateEnable)
    else $error("clock gate not set by reset");

  // guards on the shift engine between edges and on slave pin routing
  sequence shiftIdle;
    ceAct && busy && !edgeEv && !abort;
  endsequence
  sequence slaveCut;
    ceAct && busy && !master && !selected;
  endsequence
  sequence slaveStart;
    start && !master;
  endsequence

  a_first_bit: assert property (masterStart |=>
    outBit_r == msbOf($past(txOut.data), lsbf))
    else $error("first data bit not presented at start");

  a_shift_hold: assert property (shiftIdle |=>
    $stable(sh_r) && $stable(edgeCnt_r))
    else $error("shifter moved without a clock edge");

  a_slave_cut: assert property (slaveCut |=>
    !busy && edgeCnt_r == '0)
    else $error("deselect did not end the byte");

  a_slave_arm: assert property (slaveStart |=>
    busy)
    else $error("selected slave did not arm");

  a_idle_hold: assert property (ceAct && !busy && !start |=>
    !busy)
    else $error("transfer began without a start");

  a_tick_master: assert property (tick |->
    en && master && busy)
    else $error("bit clock ran outside a master byte");

  a_clock_steady: assert property (en && master &&
    !edgeEv && !abort |=> $stable(sckAct_r))
    else $error("serial clock moved between edges");

  a_slave_pins: assert property (en && !master |->
    !serialClockDriveEn && !selectDriveEn && !mosiDriveEn)
    else $error("slave drives a master pin");

  a_miso_release: assert property (en && !master &&
    !bidir && selectSense |-> !misoDriveEn)
    else $error("deselected slave drives its data pin");

  a_rx_clear: assert property (ceAct && en && rxRead &&
    !done |=> !receiveFullFlag)
    else $error("read did not clear receive flag");

  a_rx_keep: assert property (done && rxRead |=>
    receiveFullFlag)
    else $error("completion lost to a same-cycle read");
endmodule : spi_port

// [tb/spi_slave_model.sv]
// Purpose: far-side serial slave facing the port in master mode
// Assumes: pin levels seen at bus clock edges
// Notes: a released data line shows its last level inverted
`timescale 1ns/1ps
module spi_slave_model import spi_pkg::*; (
  input wire logic clk, // bus clock
  input wire logic selN, // select, low
  input wire logic sck, // serial clock
  input wire logic mosi, // data in
  input wire logic clock_polarity_bit, // idle level
  input wire logic clock_phase_bit, // phase
  input wire logic lsbf, // lsb first
  input wire logic [DATA_W-1:0] reply, // byte out
  output logic miso, // data out
  output logic [DATA_W-1:0] got // byte in
);
  logic prevSck = 1'b0;
  logic lastOut = 1'b0;
  logic [DATA_W-1:0] rx = 8'h00;
  int k = 0;
  int edges = 0;
  function automatic int idx(input int n);
    return lsbf ? n : DATA_W - 1 - n;
  endfunction : idx
  always_comb begin
    int j;
    j = clock_phase_bit ? k - 1 : k;
    // inverted so a stale level can never pass for data
    if (selN || j < 0 || j > 7) miso = ~lastOut;
    else miso = reply[idx(j)];
  end
  always @(posedge clk) begin
    logic [DATA_W-1:0] t;
    logic lead;
    prevSck <= sck;
    lastOut <= miso;
    t = rx;
    lead = sck != clock_polarity_bit;
    // select may rise in the cycle that shows the final clock edge
    if (sck !== prevSck && (!selN || edges == 15)) begin
      if (lead ^ clock_phase_bit) t[idx(clock_phase_bit ? k - 1 : k)] = mosi;
      if (lead == clock_phase_bit) k <= k + 1;
      edges <= edges + 1;
      if (edges == 15) begin
        got <= t;
        k <= 0;
        edges <= 0;
      end
    end else if (selN) begin
      k <= 0;
      edges <= 0;
    end
    rx <= t;
  end
endmodule : spi_slave_model

// [tb/testbench.sv]
// Purpose: self-checking bench for the serial port block
// Assumes: slave model on the master pins
// Notes: the bench plays the external master in slave tests
`timescale 1ns/1ps
module testbench import spi_pkg::*;;
  logic clk = 1'b0;
  logic rstn, clkEn, stopShallow, stopDeep, gateWrite, gateValue, en;
  logic master_select_bit, clock_polarity_bit, clock_phase_bit, lsbf, bidir, oe, modf, select_output_enable;
  logic txValid, rxRead, bSck, bMosi, bSel;
  logic [PRE_W-1:0] pre;
  logic [RATE_W-1:0] rate;
  logic [DATA_W-1:0] txData, reply, rxData, got;
  logic txReady, transmitEmptyFlag, receiveFullFlag, busy, gateEnable;
  logic sckD, sckE, mosiD, mosiE, misoD, misoE, selD, selE;
  logic sckPin, mosiPin, misoPin, selPin, modelMiso;
  logic [PIN_N-1:0] pinOwned;
  int fails = 0;
  int checks = 0;
  assign sckPin = sckE ? sckD : bSck;
  assign mosiPin = mosiE ? mosiD : bMosi;
  assign misoPin = misoE ? misoD : modelMiso;
  assign selPin = selE ? selD : bSel;
  always #25 clk = ~clk;
  spi_port dut (.clk(clk), .rstn(rstn), .clkEn(clkEn),
    .stopShallow(stopShallow), .stopDeep(stopDeep),
    .gateWrite(gateWrite), .gateValue(gateValue), .gateEnable(gateEnable),
    .systemEnableBit(en), .masterSelectBit(master_select_bit),
    .clockPolarityBit(clock_polarity_bit), .clockPhaseBit(clock_phase_bit),
    .shiftDirectionBit(lsbf), .bidirPinControl(bidir),
    .bidirOutputEnable(oe), .modeFaultEnable(modf),
    .selectOutputEnable(select_output_enable), .prescaleSelect(pre), .rateSelect(rate),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .transmitEmptyFlag(transmitEmptyFlag), .rxRead(rxRead),
    .rxData(rxData), .receiveFullFlag(receiveFullFlag), .busy(busy),
    .serialClockSense(sckPin), .serialClockDrive(sckD),
    .serialClockDriveEn(sckE), .mosiSense(mosiPin), .mosiDrive(mosiD),
    .mosiDriveEn(mosiE), .misoSense(misoPin), .misoDrive(misoD),
    .misoDriveEn(misoE), .selectSense(selPin), .selectDrive(selD),
    .selectDriveEn(selE), .pinOwned(pinOwned));
  spi_slave_model far (.clk(clk), .selN(selPin | ~master_select_bit), .sck(sckPin),
    .mosi(mosiPin), .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit), .lsbf(lsbf),
    .reply(reply), .miso(modelMiso), .got(got));
  task chk(input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task setup(input logic [3:0] m, input logic [2:0] p, input logic [3:0] r);
    @(posedge clk);
    {master_select_bit, clock_polarity_bit, clock_phase_bit, lsbf} <= m;
    {pre, rate} <= {p, r};
    {en, modf, select_output_enable, bidir} <= 4'b1110;
  endtask : setup
  task push(input logic [7:0] b);
    int c;
    c = 0;
    @(posedge clk);
    txData <= b;
    txValid <= 1'b1;
    do begin
      @(negedge clk);
      c++;
    end while (txReady !== 1'b1 && c < 100);
    @(posedge clk);
    txValid <= 1'b0;
    chk(c < 100, 1'b1);
  endtask : push
  task wait_busy(input logic lvl);
    int c;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (busy !== lvl && c < 1000);
    chk(c < 1000, 1'b1);
  endtask : wait_busy
  // half periods are timed from toggle to toggle, one cycle of slack none
  task mxfer(input logic [7:0] tx, input logic [7:0] rep, input int h);
    int n, c, last;
    logic prev;
    @(posedge clk);
    reply <= rep;
    push(tx);
    wait_busy(1'b1);
    {n, c, last} = '0;
    prev = sckPin;
    while (busy === 1'b1 && c < 40000) begin
      @(negedge clk);
      c++;
      if (sckPin !== prev) begin
        n++;
        if (n > 1) chk(c - last, h);
        last = c;
        prev = sckPin;
      end
    end
    repeat (2) @(negedge clk);
    chk(n, 16);
    chk(sckPin, clock_polarity_bit);
    chk({receiveFullFlag, rxData}, {1'b1, rep});
    chk(got, tx);
    @(posedge clk);
    rxRead <= 1'b1;
    @(posedge clk);
    rxRead <= 1'b0;
  endtask : mxfer
  task t_pins;
    logic [6:0] e;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {en, modf, bSel} <= {2'b10, i[2]};
      {master_select_bit, bidir, oe} <= i[2:0];
      repeat (3) @(negedge clk);
      e = {!master_select_bit, !(bidir && master_select_bit), !(bidir && !master_select_bit), 1'b1, master_select_bit,
        master_select_bit && (!bidir || oe), !master_select_bit && (!bidir || oe)};
      chk(pinOwned, e[6:3]);
      chk({sckE, mosiE, misoE}, e[2:0]);
    end
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      {bidir, modf, select_output_enable} <= {1'b0, j[1:0]};
      repeat (2) @(negedge clk);
      chk(pinOwned[PIN_SEL], modf);
      chk(selE, modf & select_output_enable);
    end
  endtask : t_pins
  task t_rates;
    logic [2:0] p[4] = '{3'h2, 3'h7, 3'h0, 3'h7};
    logic [3:0] r[4] = '{4'h1, 4'h1, 4'hf, 4'h8};
    int h[4] = '{6, 16, 256, 2048};
    for (int i = 0; i < 4; i++) begin
      setup({1'b1, i[1:0], i[0] ^ i[1]}, 3'h1, 4'h2);
      mxfer({i[1:0], 6'h2d}, {6'h31, i[1:0]}, 8);
    end
    for (int i = 0; i < 4; i++) begin
      setup(4'b1000, p[i], r[i]);
      mxfer(8'h3c ^ i[7:0], 8'hc3, h[i]);
    end
  endtask : t_rates
  task t_fifo;
    setup(4'b0000, 3'h1, 4'h2);
    reply <= 8'h77;
    for (int i = 0; i < 8; i++) push(8'h10 + i[7:0]);
    @(posedge clk);
    txValid <= 1'b1;
    repeat (3) @(negedge clk);
    chk({txReady, transmitEmptyFlag}, 2'b00);
    @(posedge clk);
    txValid <= 1'b0;
    master_select_bit <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (2) @(negedge clk);
      chk(got, 8'h10 + i[7:0]);
    end
    chk({transmitEmptyFlag, receiveFullFlag, rxData}, 10'h377);
  endtask : t_fifo
  task t_abort;
    setup(4'b1000, 3'h1, 4'h2);
    push(8'ha5);
    push(8'h5a);
    repeat (30) @(posedge clk);
    en <= 1'b0;
    repeat (2) @(negedge clk);
    chk({busy, receiveFullFlag, transmitEmptyFlag}, 3'h1);
    chk(pinOwned, 4'h0);
  endtask : t_abort
  task t_slave;
    logic [7:0] m, s;
    m = 8'hb4;
    setup(4'b0000, 3'h0, 4'h0);
    push(8'h4e);
    @(posedge clk);
    bSel <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      bMosi <= m[i];
      repeat (4) @(posedge clk);
      s[i] = misoPin;
      bSck <= 1'b1;
      repeat (4) @(posedge clk);
      bSck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    bSel <= 1'b1;
    bMosi <= ~m[0];
    repeat (3) @(negedge clk);
    chk(s, 8'h4e);
    chk({receiveFullFlag, rxData}, {1'b1, m});
    chk(misoE, 1'b0);
  endtask : t_slave
  task t_stop;
    logic v;
    setup(4'b1000, 3'h1, 4'h2);
    reply <= 8'h69;
    push(8'h3a);
    wait_busy(1'b1);
    repeat (20) @(posedge clk);
    stopShallow <= 1'b1;
    repeat (2) @(negedge clk);
    v = sckPin;
    repeat (40) @(negedge clk);
    chk({busy, sckPin}, {1'b1, v});
    @(posedge clk);
    stopShallow <= 1'b0;
    wait_busy(1'b0);
    repeat (2) @(negedge clk);
    chk({receiveFullFlag, rxData, got}, 17'h1693a);
    @(posedge clk);
    stopDeep <= 1'b1;
    @(posedge clk);
    stopDeep <= 1'b0;
    gateWrite <= 1'b1;
    @(negedge clk);
    chk({receiveFullFlag, rxData, gateEnable}, 10'h001);
    @(posedge clk);
    gateWrite <= 1'b0;
    @(negedge clk);
    chk(gateEnable, 1'b0);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(gateEnable, 1'b1);
  endtask : t_stop
  initial begin
    {rstn, stopShallow, stopDeep, gateWrite, gateValue, en, master_select_bit} = '0;
    {clock_polarity_bit, clock_phase_bit, lsbf, bidir, oe, modf, select_output_enable, txValid, rxRead} = '0;
    {clkEn, bSel, bSck, bMosi, pre, rate, txData, reply} = 27'h6000000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(gateEnable, 1'b1);
    chk({busy, receiveFullFlag, transmitEmptyFlag}, 3'h1);
    chk({rxData, pinOwned, sckE, mosiE, misoE, selE}, 16'h0000);
    t_pins();
    t_rates();
    t_fifo();
    t_abort();
    t_slave();
    t_stop();
    final_report();
  end
  // budget is about twice the expected run length
  initial begin
    #4_500_000;
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end
endmodule : testbench
